// File: logic/serial_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface serial_link_if;
  logic serial_input_pin;  // host to device, idles high
  logic serial_output_pin; // device to host, idles high
  logic cts_b;             // device may take data when low
  logic rts_b;             // host may take data when low
  modport device (input serial_input_pin, input rts_b,
                  output serial_output_pin, output cts_b);
  modport host (output serial_input_pin, output rts_b,
                input serial_output_pin, input cts_b);
endinterface
`default_nettype wire

// File: logic/serial_port_device.sv
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - idle serial line stays high
// - start low, 8 bits LSB first, stop high
// - both ends share baud and framing
// - every received byte buffered until radio takes it (code drops a byte arriving at full capacity and sets the input overflow flag)
// - keep buffering while radio reception runs
// - request send on silence, payload, command sequence
// - send only when no radio traffic
// - input capacity follows payload size and parity
// - clear-to-send drops at threshold before full
// - clear-to-send high when input buffer full
// - host stops sending while clear-to-send high
// - clear-to-send low again with 34 free
// - host prefers short messages or slower baud
// - radio data buffered then sent to host
// - output buffer full drops new radio data
// - request pin config 2 holds output
// - software handshake selectable, ASCII only
module serial_port_device
  import serial_port_pkg::*;
#(
  parameter int CPB       = CLKS_PER_BIT,
  parameter int DIN_DEP   = DIN_DEPTH,
  parameter int DOUT_DEP  = DOUT_DEPTH
) (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  serial_link_if.device   link,
  // apb slave
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pwrite,
  input  wire logic [7:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]     prdata,
  output logic            pready,
  output logic            pslverr,
  // radio side
  input  wire logic       radio_busy,
  output logic            radio_tx_req,
  output logic            radio_rd_valid,
  input  wire logic       radio_rd_ready,
  output logic [7:0]      radio_rd_data,
  input  wire logic       radio_wr_valid,
  output logic            radio_wr_ready,
  input  wire logic [7:0] radio_wr_data
);
  localparam int CW = $clog2(CPB);
  localparam int LW = $clog2(DIN_DEP) + 1;

  if (CPB < 4 || DIN_DEP < 2 * FREE_RESUME)
    $error("serial_port_device: CPB or DIN_DEP too small");

  // configuration and status
  logic [3:0]  ctrl_reg;
  logic [15:0] pkt_reg;
  logic [15:0] tmo_reg;
  logic [7:0]  flow_reg;
  logic        din_ovf_reg;
  logic        dout_ovf_reg;
  logic [1:0]  req_pin_cfg;
  logic        sw_en;
  logic [7:0]  max_payload;
  logic [7:0]  byte_thr;
  assign req_pin_cfg = ctrl_reg[1:0];
  assign sw_en       = ctrl_reg[CTRL_SWHS_BIT];
  assign max_payload = pkt_reg[7:0];
  assign byte_thr    = pkt_reg[PKT_THR_LSB +: 8];

  // serial receiver
  ser_state_t rx_state_reg;
  logic [CW-1:0] rx_cnt_reg;
  logic [2:0]    rx_bit_reg;
  logic [7:0]    rx_sh_reg;
  logic          rx_done_reg;
  logic          rxd;
  assign rxd = link.serial_input_pin;

  // mid-bit sampling, stop bit must be high to count
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rx_state_reg <= S_IDLE;
      rx_cnt_reg   <= '0;
      rx_bit_reg   <= '0;
      rx_sh_reg    <= '0;
      rx_done_reg  <= 1'b0;
    end else begin
      rx_done_reg <= 1'b0;
      if (rx_cnt_reg != '0) begin
        rx_cnt_reg <= rx_cnt_reg - CW'(1);
      end else begin
        unique case (rx_state_reg)
          S_IDLE: if (!rxd) begin
            rx_state_reg <= S_START;
            rx_cnt_reg   <= CW'(CPB / 2 - 1);
          end
          S_START: begin
            rx_state_reg <= rxd ? S_IDLE : S_DATA;
            rx_cnt_reg   <= CW'(CPB - 1);
            rx_bit_reg   <= '0;
          end
          S_DATA: begin
            rx_sh_reg  <= {rxd, rx_sh_reg[7:1]};
            rx_cnt_reg <= CW'(CPB - 1);
            rx_bit_reg <= rx_bit_reg + 3'd1;
            if (rx_bit_reg == 3'd7) rx_state_reg <= S_STOP;
          end
          S_STOP: begin
            rx_state_reg <= S_IDLE;
            rx_done_reg  <= rxd;
          end
        endcase
      end
    end
  end

  // software handshake filtering of host characters
  logic rx_is_ctl;
  logic xoff_reg;
  assign rx_is_ctl = sw_en && (rx_sh_reg == XON_CHR || rx_sh_reg == XOFF_CHR);

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      xoff_reg <= 1'b0;
    end else if (!sw_en) begin
      xoff_reg <= 1'b0;
    end else if (rx_done_reg && rx_is_ctl) begin
      xoff_reg <= (rx_sh_reg == XOFF_CHR);
    end
  end

  // input buffer with capacity from payload and parity
  logic [LW-1:0] din_level;
  logic [LW-1:0] din_cap;
  logic [LW-1:0] din_free;
  logic          din_ready;
  logic          din_push;
  logic          din_drop;
  logic          din_pop_ok;
  int            cap_base;
  int            cap_pay;

  always_comb begin
    cap_base = DIN_DEP;
    cap_pay  = PAYLOAD_MULT * int'(max_payload);
    if (ctrl_reg[CTRL_PAR_BIT]) cap_base = DIN_DEP - PARITY_SHRINK;
    if (max_payload != 8'h00 && cap_pay < cap_base) cap_base = cap_pay;
    if (cap_base < FREE_RESUME) cap_base = FREE_RESUME;
    din_cap = LW'(cap_base);
  end

  assign din_free = din_cap - din_level;
  // bytes keep landing here whatever the radio is doing
  assign din_push = rx_done_reg && !rx_is_ctl && din_ready
                    && (din_level < din_cap);
  assign din_drop = rx_done_reg && !rx_is_ctl && !din_push;

  stream_fifo #(.WIDTH(8), .DEPTH(DIN_DEP)) din_fifo (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .in_valid  (rx_done_reg && !rx_is_ctl && (din_level < din_cap)),
    .in_ready  (din_ready),
    .in_data   (rx_sh_reg),
    .out_valid (radio_rd_valid),
    .out_ready (radio_rd_ready && din_pop_ok),
    .out_data  (radio_rd_data),
    .level     (din_level)
  );

  // baud tick and silence measured in bit times
  logic [CW-1:0] tick_cnt_reg;
  logic [15:0]   sil_reg;
  logic [1:0]    cmd_run_reg;
  logic          pend_reg;
  logic          tick;
  logic          fire;
  assign tick = (tick_cnt_reg == '0);

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick ? CW'(CPB - 1) : tick_cnt_reg - CW'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sil_reg <= '0;
    end else if (rx_done_reg || rx_state_reg != S_IDLE) begin
      sil_reg <= '0;
    end else if (tick && sil_reg != 16'hFFFF) begin
      sil_reg <= sil_reg + 16'd1;
    end
  end

  // run of command characters
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cmd_run_reg <= '0;
    end else if (cmd_run_reg == 2'(CMD_RUN)) begin
      cmd_run_reg <= '0; // one request per sequence
    end else if (din_push) begin
      if (rx_sh_reg != CMD_CHR) cmd_run_reg <= '0;
      else if (cmd_run_reg != 2'(CMD_RUN)) cmd_run_reg <= cmd_run_reg + 2'd1;
    end
  end

  assign fire = (tmo_reg != '0 && sil_reg >= tmo_reg && din_level != '0)
             || (byte_thr != 8'h00 && din_level >= LW'(byte_thr))
             || (max_payload != 8'h00 && din_level >= LW'(max_payload))
             || (cmd_run_reg == 2'(CMD_RUN));

  // request persists until the buffer has drained
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pend_reg <= 1'b0;
    end else if (fire) begin
      pend_reg <= 1'b1;
    end else if (din_level == '0) begin
      pend_reg <= 1'b0;
    end
  end

  assign din_pop_ok   = pend_reg && !radio_busy;
  assign radio_tx_req = pend_reg && !radio_busy && (din_level != '0);

  // clear-to-send with hysteresis down to the resume margin
  logic cts_hold_reg;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cts_hold_reg <= 1'b0;
    end else if (din_level >= din_cap) begin
      cts_hold_reg <= 1'b1;
    end else if (din_free <= LW'(flow_reg)) begin
      cts_hold_reg <= 1'b1;
    end else if (din_free >= LW'(FREE_RESUME)) begin
      cts_hold_reg <= 1'b0;
    end
  end
  assign link.cts_b = cts_hold_reg;

  // output buffer, radio data dropped when full
  logic       dout_valid;
  logic       dout_take;
  logic [7:0] dout_data;
  logic       dout_ready;
  assign radio_wr_ready = 1'b1;

  stream_fifo #(.WIDTH(8), .DEPTH(DOUT_DEP)) dout_fifo (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .in_valid  (radio_wr_valid),
    .in_ready  (dout_ready),
    .in_data   (radio_wr_data),
    .out_valid (dout_valid),
    .out_ready (dout_take),
    .out_data  (dout_data),
    .level     ()
  );

  // serial transmitter
  ser_state_t tx_state_reg;
  logic [CW-1:0] tx_cnt_reg;
  logic [2:0]    tx_bit_reg;
  logic [7:0]    tx_sh_reg;
  logic          txd_reg;
  logic          tx_hold;
  assign tx_hold   = (req_pin_cfg == RTS_CFG && link.rts_b)
                  || xoff_reg;
  assign dout_take = (tx_state_reg == S_IDLE) && dout_valid && !tx_hold;
  assign link.serial_output_pin = txd_reg;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      tx_state_reg <= S_IDLE;
      tx_cnt_reg   <= '0;
      tx_bit_reg   <= '0;
      tx_sh_reg    <= '0;
      txd_reg      <= 1'b1;
    end else if (tx_state_reg == S_IDLE) begin
      txd_reg <= 1'b1;
      if (dout_take) begin
        tx_state_reg <= S_START;
        tx_sh_reg    <= dout_data;
        tx_cnt_reg   <= CW'(CPB - 1);
        txd_reg      <= 1'b0;
      end
    end else if (tx_cnt_reg != '0) begin
      tx_cnt_reg <= tx_cnt_reg - CW'(1);
    end else begin
      tx_cnt_reg <= CW'(CPB - 1);
      unique case (tx_state_reg)
        S_START: begin
          tx_state_reg <= S_DATA;
          tx_bit_reg   <= '0;
          txd_reg      <= tx_sh_reg[0];
        end
        S_DATA: begin
          tx_bit_reg <= tx_bit_reg + 3'd1;
          if (tx_bit_reg == 3'd7) begin
            tx_state_reg <= S_STOP;
            txd_reg      <= 1'b1;
          end else begin
            txd_reg <= tx_sh_reg[tx_bit_reg + 3'd1];
          end
        end
        S_STOP: tx_state_reg <= S_IDLE;
        default: tx_state_reg <= S_IDLE;
      endcase
    end
  end

  // apb: zero wait states, read data captured in setup
  logic        wr_en;
  logic        mapped;
  logic [31:0] rd_mux;
  assign wr_en  = psel && penable && pwrite;
  assign mapped = paddr == CTRL_OFS || paddr == PKT_OFS || paddr == TMO_OFS
               || paddr == FLOW_OFS || paddr == STATUS_OFS;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      CTRL_OFS:   rd_mux[3:0]  = ctrl_reg;
      PKT_OFS:    rd_mux[15:0] = pkt_reg;
      TMO_OFS:    rd_mux[15:0] = tmo_reg;
      FLOW_OFS:   rd_mux[7:0]  = flow_reg;
      STATUS_OFS: begin
        rd_mux[ST_DIN_OVF_BIT] = din_ovf_reg;
        rd_mux[ST_DOUT_OVF]    = dout_ovf_reg;
        rd_mux[ST_CTS_BIT]     = cts_hold_reg;
        rd_mux[ST_PEND_BIT]    = pend_reg;
        rd_mux[ST_LEVEL_LSB +: LW] = din_level;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= rd_mux;
    end
  end

  // configuration writes
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ctrl_reg <= CTRL_RST;
      pkt_reg  <= PKT_RST;
      tmo_reg  <= TMO_RST;
      flow_reg <= FLOW_RST;
    end else if (wr_en) begin
      if (paddr == CTRL_OFS) ctrl_reg <= pwdata[3:0];
      if (paddr == PKT_OFS) pkt_reg <= pwdata[15:0];
      if (paddr == TMO_OFS) tmo_reg <= pwdata[15:0];
      if (paddr == FLOW_OFS) flow_reg <= pwdata[7:0];
    end
  end

  // sticky loss flags, write one to clear; a new loss wins
  logic clr_st;
  assign clr_st = wr_en && paddr == STATUS_OFS;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      din_ovf_reg  <= 1'b0;
      dout_ovf_reg <= 1'b0;
    end else begin
      din_ovf_reg <= (din_ovf_reg && !(clr_st && pwdata[ST_DIN_OVF_BIT]))
                  || din_drop;
      dout_ovf_reg <= (dout_ovf_reg && !(clr_st && pwdata[ST_DOUT_OVF]))
                   || (radio_wr_valid && !dout_ready);
    end
  end
endmodule
`default_nettype wire

// File: logic/serial_port_host.sv
`timescale 1ns/1ps
`default_nettype none
module serial_port_host
  import serial_port_pkg::*;
#(
  parameter int CPB = CLKS_PER_BIT
) (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  serial_link_if.host     link,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic [7:0] tx_data,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  input  wire logic       rx_hold,
  input  wire logic       sw_handshake_enable,
  input  wire logic       xoff_req
);
  localparam int CW = $clog2(CPB);
  if (CPB < 4) $error("serial_port_host: CPB too small");

  // request line follows the user hold
  logic rts_reg;
  always_ff @(posedge mclk) begin
    if (!rst_b) rts_reg <= 1'b0;
    else rts_reg <= rx_hold;
  end
  assign link.rts_b = rts_reg;

  // pending software handshake character on a change of xoff_req
  logic xoff_sent_reg;
  logic ctl_due;
  assign ctl_due = sw_handshake_enable && (xoff_req != xoff_sent_reg);

  ser_state_t tx_state_reg;
  logic [CW-1:0] tx_cnt_reg;
  logic [3:0]    tx_bit_reg;
  logic [9:0]    tx_sh_reg;
  logic          start_ok;
  assign start_ok = (tx_state_reg == S_IDLE) && !link.cts_b;
  assign tx_ready = start_ok && !ctl_due;
  assign link.serial_input_pin = tx_sh_reg[0];

  // frame shifts out start, data LSB first, stop as one word
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      tx_state_reg  <= S_IDLE;
      tx_cnt_reg    <= '0;
      tx_bit_reg    <= '0;
      tx_sh_reg     <= 10'h3FF;
      xoff_sent_reg <= 1'b0;
    end else if (tx_state_reg == S_IDLE) begin
      if (!sw_handshake_enable) xoff_sent_reg <= xoff_req;
      if (start_ok && (ctl_due || tx_valid)) begin
        tx_state_reg <= S_DATA;
        tx_cnt_reg   <= CW'(CPB - 1);
        tx_bit_reg   <= '0;
        if (ctl_due) begin
          xoff_sent_reg <= xoff_req;
          tx_sh_reg <= {1'b1, xoff_req ? XOFF_CHR : XON_CHR, 1'b0};
        end else begin
          tx_sh_reg <= {1'b1, tx_data, 1'b0};
        end
      end
    end else if (tx_cnt_reg != '0) begin
      tx_cnt_reg <= tx_cnt_reg - CW'(1);
    end else begin
      tx_cnt_reg <= CW'(CPB - 1);
      tx_sh_reg  <= {1'b1, tx_sh_reg[9:1]};
      tx_bit_reg <= tx_bit_reg + 4'd1;
      if (tx_bit_reg == 4'd9) tx_state_reg <= S_IDLE;
    end
  end

  // receiver, sampled mid-bit
  logic [CW-1:0] rx_cnt_reg;
  logic [3:0]    rx_bit_reg;
  logic          rx_busy_reg;
  logic [7:0]    rx_sh_reg;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rx_cnt_reg  <= '0;
      rx_bit_reg  <= '0;
      rx_busy_reg <= 1'b0;
      rx_sh_reg   <= '0;
      rx_data     <= '0;
      rx_valid    <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (!rx_busy_reg) begin
        if (!link.serial_output_pin) begin
          rx_busy_reg <= 1'b1;
          rx_cnt_reg  <= CW'(CPB / 2 - 1);
          rx_bit_reg  <= '0;
        end
      end else if (rx_cnt_reg != '0) begin
        rx_cnt_reg <= rx_cnt_reg - CW'(1);
      end else begin
        rx_cnt_reg <= CW'(CPB - 1);
        rx_bit_reg <= rx_bit_reg + 4'd1;
        if (rx_bit_reg == 4'd0 && link.serial_output_pin) begin
          rx_busy_reg <= 1'b0;
        end else if (rx_bit_reg == 4'd9) begin
          rx_busy_reg <= 1'b0;
          rx_data     <= rx_sh_reg;
          rx_valid    <= link.serial_output_pin;
        end else if (rx_bit_reg != 4'd0) begin
          rx_sh_reg <= {link.serial_output_pin, rx_sh_reg[7:1]};
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: logic/serial_port_pkg.sv
package serial_port_pkg;
  // timing and sizes
  localparam int CLK_HZ        = 40_000_000;
  localparam int BAUD_BPS      = 115_200;
  localparam int CLKS_PER_BIT  = CLK_HZ / BAUD_BPS;
  localparam int DATA_BITS     = 8;
  localparam int DIN_DEPTH     = 128;
  localparam int DOUT_DEPTH    = 32;
  localparam int FREE_RESUME   = 34;
  localparam int PARITY_SHRINK = 16;
  localparam int PAYLOAD_MULT  = 2;
  // register offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] PKT_OFS    = 8'h04;
  localparam logic [7:0] TMO_OFS    = 8'h08;
  localparam logic [7:0] FLOW_OFS   = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  // field positions
  localparam int CTRL_SWHS_BIT  = 2;
  localparam int CTRL_PAR_BIT   = 3;
  localparam int PKT_THR_LSB    = 8;
  localparam int ST_DIN_OVF_BIT = 0;
  localparam int ST_DOUT_OVF    = 1;
  localparam int ST_CTS_BIT     = 2;
  localparam int ST_PEND_BIT    = 3;
  localparam int ST_LEVEL_LSB   = 8;
  // reset values
  localparam logic [3:0]  CTRL_RST = 4'h0;
  localparam logic [15:0] PKT_RST  = 16'h0140;
  localparam logic [15:0] TMO_RST  = 16'h0003;
  localparam logic [7:0]  FLOW_RST = 8'h11;
  // codes
  localparam logic [1:0] RTS_CFG  = 2'h2;
  localparam logic [7:0] XON_CHR  = 8'h11;
  localparam logic [7:0] XOFF_CHR = 8'h13;
  localparam logic [7:0] CMD_CHR  = 8'h2B;
  localparam int         CMD_RUN  = 3;

  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_START = 4'b0010,
    S_DATA  = 4'b0100,
    S_STOP  = 4'b1000
  } ser_state_t;
endpackage

// File: logic/stream_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module stream_fifo
  import serial_port_pkg::*;
#(
  parameter int WIDTH = DATA_BITS,
  parameter int DEPTH = DOUT_DEPTH
) (
  input  wire logic                     mclk,
  input  wire logic                     rst_b,
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [WIDTH-1:0]         in_data,
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [WIDTH-1:0]              out_data,
  output logic [$clog2(DEPTH):0]        level
);
  localparam int AW = $clog2(DEPTH);

  // pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
    $error("stream_fifo: DEPTH must be a power of two");

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      level_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (level_reg != AW'(0) + (AW+1)'(DEPTH));
  assign out_valid = (level_reg != '0);
  assign out_data  = mem[rd_ptr_reg];
  assign level     = level_reg;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage, no reset needed on the array
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      level_reg  <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + AW'(1);
      if (pop) rd_ptr_reg <= rd_ptr_reg + AW'(1);
      level_reg <= level_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// File: tb/serial_port_buffer_flow_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module serial_port_buffer_flow_control_bench
  import serial_port_pkg::*;
();
  localparam int CPB = 8;
  localparam int BIT = 10 * CPB; // cycles per frame
  logic        mclk, rst_b, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr, tx_data, rx_data, radio_rd_data, radio_wr_data;
  logic [31:0] pwdata, prdata, q;
  logic        radio_busy, radio_tx_req, radio_rd_valid, radio_rd_ready;
  logic        radio_wr_valid, radio_wr_ready, tx_valid, tx_ready;
  logic        rx_valid, rx_hold, sw_handshake_enable, xoff_req;
  logic [9:0]  f;
  logic [7:0]  rxq[$];
  int          bad_count, cmp_count;
  serial_link_if serial_link_if_i ();
  wire logic   si_w = serial_link_if_i.serial_input_pin;
  wire logic   so_w = serial_link_if_i.serial_output_pin;
  wire logic   cts_w = serial_link_if_i.cts_b;
  serial_port_device #(.CPB(CPB)) serial_port_device_i (
    .mclk, .rst_b, .link(serial_link_if_i), .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .radio_busy,
    .radio_tx_req, .radio_rd_valid, .radio_rd_ready, .radio_rd_data,
    .radio_wr_valid, .radio_wr_ready, .radio_wr_data);
  serial_port_host #(.CPB(CPB)) serial_port_host_i (
    .mclk, .rst_b, .link(serial_link_if_i), .tx_valid, .tx_ready,
    .tx_data, .rx_valid, .rx_data, .rx_hold, .sw_handshake_enable,
    .xoff_req);
  serial_port_checker #(.CPB(CPB)) serial_port_checker_i (
    .mclk, .rst_b, .serial_input_pin(si_w), .serial_output_pin(so_w),
    .cts_b(cts_w), .rts_b(serial_link_if_i.rts_b));
  // 40 MHz clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // bytes delivered to the host user side
  always @(posedge mclk) begin
    if (rx_valid === 1'b1) rxq.push_back(rx_data);
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, read data and error land in q and e
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic send(input logic [7:0] b);
    @(posedge mclk);
    tx_valid <= 1'b1;
    tx_data <= b;
    do @(posedge mclk); while (tx_ready !== 1'b1);
    tx_valid <= 1'b0;
  endtask
  task automatic push(input logic [7:0] b);
    @(posedge mclk);
    radio_wr_valid <= 1'b1;
    radio_wr_data <= b;
    do @(posedge mclk); while (radio_wr_ready !== 1'b1);
    radio_wr_valid <= 1'b0;
  endtask
  task automatic drain(input logic [7:0] b);
    @(posedge mclk);
    radio_rd_ready <= 1'b1;
    do @(posedge mclk); while (radio_rd_valid !== 1'b1);
    chk(radio_rd_data, b);
    radio_rd_ready <= 1'b0;
  endtask
  // samples one host frame mid-bit, start bit in f[0]
  task automatic grab();
    wait (si_w === 1'b0);
    tick(CPB / 2);
    for (int i = 0; i < 10; i++) begin
      f[i] = si_w;
      tick(CPB);
    end
  endtask
  task automatic t_cmd();
    chk(si_w, 1'b1);
    apb(1'b0, 8'h14, 32'h0);
    chk(e, 1'b1);
    apb(1'b1, TMO_OFS, 32'h0);
    apb(1'b1, PKT_OFS, 32'h3F40);
    fork
      grab();
      send(XOFF_CHR);
    join
    chk(f, {1'b1, XOFF_CHR, 1'b0});
    send(CMD_CHR);
    send(CMD_CHR);
    tick(BIT + CPB);
    chk(radio_tx_req, 1'b0);
    send(CMD_CHR);
    tick(BIT + CPB);
    chk(radio_tx_req, 1'b1);
    drain(XOFF_CHR);
    for (int i = 0; i < 3; i++) drain(CMD_CHR);
  endtask
  task automatic t_tmo();
    apb(1'b1, TMO_OFS, 32'h3);
    radio_busy <= 1'b1;
    send(8'h41);
    tick(BIT + 6 * CPB);
    chk(radio_tx_req, 1'b0);
    radio_busy <= 1'b0;
    tick(2);
    chk(radio_tx_req, 1'b1);
    drain(8'h41);
  endtask
  // capacity 64 from payload 0x20, hold-off at 5 free
  task automatic t_cts();
    apb(1'b1, PKT_OFS, 32'h3F20);
    apb(1'b1, FLOW_OFS, 32'h5);
    radio_busy <= 1'b1;
    for (int i = 0; i < 59; i++) begin
      if (i == 58) begin
        tick(BIT + CPB);
        chk(cts_w, 1'b0);
      end
      send(8'(i));
    end
    tick(BIT + CPB);
    chk(cts_w, 1'b1);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(q[ST_LEVEL_LSB +: 8], 8'h3B);
    chk(q[ST_DIN_OVF_BIT], 1'b0);
    // parity trims capacity to 112
    apb(1'b1, FLOW_OFS, 32'h35);
    apb(1'b1, CTRL_OFS, 32'h1 << CTRL_PAR_BIT);
    apb(1'b1, PKT_OFS, 32'h3F00);
    tick(2);
    chk(cts_w, 1'b1);
    apb(1'b1, CTRL_OFS, 32'h0);
    tick(2);
    chk(cts_w, 1'b0);
    apb(1'b1, PKT_OFS, 32'h3F20);
    apb(1'b1, FLOW_OFS, 32'h5);
    radio_busy <= 1'b0;
    for (int i = 0; i < 59; i++) begin
      if (i == 28 || i == 29) begin
        tick(2);
        chk(cts_w, i == 28);
      end
      drain(8'(i));
    end
  endtask
  task automatic t_out();
    rx_hold <= 1'b1;
    apb(1'b1, CTRL_OFS, 32'(RTS_CFG));
    for (int i = 0; i < 33; i++) push(8'hA0 + 8'(i));
    tick(2 * BIT);
    chk(rxq.size(), 32'h0);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(q[ST_DOUT_OVF], 1'b1);
    apb(1'b1, STATUS_OFS, 32'h2);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(q[ST_DOUT_OVF], 1'b0);
    rx_hold <= 1'b0;
    tick(34 * BIT);
    chk(rxq.size(), 32'h20);
    for (int i = 0; i < 32; i++) chk(rxq[i], 8'hA0 + 8'(i));
  endtask
  task automatic t_xoff();
    apb(1'b1, CTRL_OFS, 32'(RTS_CFG) | (32'h1 << CTRL_SWHS_BIT));
    sw_handshake_enable <= 1'b1;
    xoff_req <= 1'b1;
    tick(2 * BIT);
    rxq.delete();
    push(8'h55);
    tick(3 * BIT);
    chk(rxq.size(), 32'h0);
    xoff_req <= 1'b0;
    tick(4 * BIT);
    chk(rxq.size(), 32'h1);
    chk(rxq[0], 8'h55);
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // hang guard, well beyond the expected run
  initial begin
    tick(40000);
    bad_count++;
    finish_test();
  end
  initial begin
    {rst_b, psel, penable, pwrite, radio_busy, radio_rd_ready} = '0;
    {radio_wr_valid, tx_valid, rx_hold, sw_handshake_enable} = '0;
    {xoff_req, paddr, pwdata, tx_data, radio_wr_data} = '0;
    bad_count = 0;
    cmp_count = 0;
    tick(16);
    rst_b <= 1'b1;
    t_cmd();
    t_tmo();
    t_cts();
    t_out();
    t_xoff();
    finish_test();
  end
endmodule
`default_nettype wire

// File: tb/serial_port_checker.sv
`timescale 1ns/1ps
`default_nettype none
module serial_port_checker #(
  parameter int CPB = 8
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic serial_input_pin,
  input wire logic serial_output_pin,
  input wire logic cts_b,
  input wire logic rts_b
);
  localparam int FRAME = 10 * CPB;
  localparam int STOP_LO = 9 * CPB;
  localparam int STOP_MID = 9 * CPB + CPB / 2;
  logic [15:0] icnt_reg;
  logic [15:0] ocnt_reg;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  // cycles since the start bit on the host line, zero while idle
  always_ff @(posedge mclk) begin
    if (!rst_b || icnt_reg == 16'(FRAME - 1))
      icnt_reg <= 16'h0000;
    else if (icnt_reg != 16'h0000 || !serial_input_pin)
      icnt_reg <= icnt_reg + 16'h0001;
  end
  // same count for the device line
  always_ff @(posedge mclk) begin
    if (!rst_b || ocnt_reg == 16'(FRAME - 1))
      ocnt_reg <= 16'h0000;
    else if (ocnt_reg != 16'h0000 || !serial_output_pin)
      ocnt_reg <= ocnt_reg + 16'h0001;
  end
  // a low level seen while idle opens a frame
  sequence in_start;
    icnt_reg == 16'h0000 && !serial_input_pin;
  endsequence
  sequence out_start;
    ocnt_reg == 16'h0000 && !serial_output_pin;
  endsequence
  a_in_start_low:
    assert property (in_start |-> (!serial_input_pin) [*4])
    else $error("host start bit too short");
  a_in_stop_mid:
    assert property (in_start |-> ##STOP_MID serial_input_pin)
    else $error("host stop bit not high");
  a_in_stop_high:
    assert property (icnt_reg >= 16'(STOP_LO) |-> serial_input_pin)
    else $error("host line low in stop bit");
  a_out_start_low:
    assert property (out_start |-> (!serial_output_pin) [*4])
    else $error("device start bit too short");
  a_out_stop_mid:
    assert property (out_start |-> ##STOP_MID serial_output_pin)
    else $error("device stop bit not high");
  a_out_stop_high:
    assert property (ocnt_reg >= 16'(STOP_LO) |-> serial_output_pin)
    else $error("device line low in stop bit");
  // host may finish a frame in flight but must not open one
  a_cts_obeyed:
    assert property (cts_b [*4] |=> !(icnt_reg == 16'h0000
                                      && !serial_input_pin))
    else $error("host started while held off");
  a_lines_reset:
    assert property ($rose(rst_b) |-> serial_input_pin
                     && serial_output_pin && !cts_b && !rts_b)
    else $error("lines not idle after reset");
endmodule
`default_nettype wire
